// ### design/dual_uart_pin_control.sv
// Purpose: Pin-level control of a dual serial channel: interrupt drive, aux output,
//          reset hold, modem handshake pins.
// Assumes: Host control writes and channel core signals are on i_mclk.
// Notes: Pin inputs pass a two-stage synchroniser before use.
`timescale 1ns/1ns
`default_nettype none

module dual_uart_pin_control
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_reset_pin,
  input wire logic [1:0] i_ctrl_we,
  input wire logic [7:0] i_ctrl_wdata,
  input wire logic [1:0] i_irq_req,
  input wire logic [1:0] i_core_serial_out,
  input wire logic i_serial_in_a,
  input wire logic i_serial_in_b,
  input wire logic i_carrier_detect_n_a,
  input wire logic i_carrier_detect_n_b,
  input wire logic i_ring_indicator_n_a,
  input wire logic i_ring_indicator_n_b,
  input wire logic i_clear_send_n_a,
  input wire logic i_clear_send_n_b,
  input wire logic i_set_ready_n_a,
  input wire logic i_set_ready_n_b,
  output logic o_serial_out_a,
  output logic o_serial_out_b,
  output logic [1:0] o_serial_in,
  output logic o_irq_out_a,
  output logic o_irq_out_a_oe,
  output logic o_irq_out_b,
  output logic o_irq_out_b_oe,
  output logic o_aux_out_two_n_a,
  output logic o_aux_out_two_n_b,
  output logic o_request_send_n_a,
  output logic o_request_send_n_b,
  output logic o_terminal_ready_n_a,
  output logic o_terminal_ready_n_b,
  output uart_pin_ctrl_pkg::modem_in_type o_modem_status_a,
  output uart_pin_ctrl_pkg::modem_in_type o_modem_status_b,
  output logic o_in_reset
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  logic [10:0] pin_raw;

  assign pin_raw = {i_reset_pin, i_serial_in_b, i_serial_in_a,
                    i_carrier_detect_n_a, i_ring_indicator_n_a, i_clear_send_n_a,
                    i_set_ready_n_a,
                    i_carrier_detect_n_b, i_ring_indicator_n_b, i_clear_send_n_b,
                    i_set_ready_n_b};

  // Idle-high serial and inactive-high modem inputs preset to one.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_reg <= uart_pin_ctrl_pkg::SYNC_PRESET;
      sync2_reg <= uart_pin_ctrl_pkg::SYNC_PRESET;
    end
    else
    begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Reset pin qualification
  // ---------------------------------------------------------------
  logic [3:0] rst_cnt_reg;
  uart_pin_ctrl_pkg::reset_state_type rst_state_reg;
  logic held;

  // A high level must persist the minimum time before it counts as reset.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_cnt_reg <= uart_pin_ctrl_pkg::RESET_CNT_ZERO;
    end
    else if (!sync2_reg[uart_pin_ctrl_pkg::PIN_RESET_IDX])
    begin
      rst_cnt_reg <= uart_pin_ctrl_pkg::RESET_CNT_ZERO;
    end
    else if (rst_cnt_reg != uart_pin_ctrl_pkg::RESET_CNT_MAX)
    begin
      rst_cnt_reg <= rst_cnt_reg + uart_pin_ctrl_pkg::RESET_CNT_ONE;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_state_reg <= uart_pin_ctrl_pkg::ST_HELD;
    end
    else
    begin
      case (rst_state_reg)
        uart_pin_ctrl_pkg::ST_HELD:
        begin
          if (!sync2_reg[uart_pin_ctrl_pkg::PIN_RESET_IDX])
          begin
            rst_state_reg <= uart_pin_ctrl_pkg::ST_RUN;
          end
        end
        uart_pin_ctrl_pkg::ST_RUN:
        begin
          if (sync2_reg[uart_pin_ctrl_pkg::PIN_RESET_IDX] &&
              rst_cnt_reg == uart_pin_ctrl_pkg::RESET_CNT_MAX)
          begin
            rst_state_reg <= uart_pin_ctrl_pkg::ST_HELD;
          end
        end
        default:
        begin
          rst_state_reg <= uart_pin_ctrl_pkg::ST_HELD;
        end
      endcase
    end
  end

  assign held = (rst_state_reg == uart_pin_ctrl_pkg::ST_HELD);

  // ---------------------------------------------------------------
  // Per-channel control and pins
  // ---------------------------------------------------------------
  logic [7:0] modem_control_reg [uart_pin_ctrl_pkg::NUM_CH];
  logic [1:0] serial_out_reg;
  logic [1:0] serial_in_reg;
  uart_pin_ctrl_pkg::irq_pins_type pins_reg [2];
  logic [1:0] rts_n_reg;
  logic [1:0] dtr_n_reg;

  for (genvar ch = 0; ch < uart_pin_ctrl_pkg::NUM_CH; ch++)
  begin : g_ch
    // Each channel owns its control byte and its own write strobe.
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        modem_control_reg[ch] <= uart_pin_ctrl_pkg::CTRL_RESET;
      end
      else if (held)
      begin
        modem_control_reg[ch] <= uart_pin_ctrl_pkg::CTRL_RESET;
      end
      else if (i_ctrl_we[ch])
      begin
        modem_control_reg[ch] <= i_ctrl_wdata;
      end
    end

    logic irq_en;

    assign irq_en = modem_control_reg[ch][uart_pin_ctrl_pkg::CTRL_IRQ_EN_BIT];

    // Interrupt enable and aux output are two faces of control bit 3.
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        pins_reg[ch] <= '{irq_value: 1'b0, irq_enable: 1'b0, aux_out_two_n: 1'b1};
      end
      else if (held)
      begin
        pins_reg[ch] <= '{irq_value: 1'b0, irq_enable: 1'b0, aux_out_two_n: 1'b1};
      end
      else
      begin
        pins_reg[ch].irq_value <= i_irq_req[ch];
        pins_reg[ch].irq_enable <= irq_en;
        pins_reg[ch].aux_out_two_n <= ~irq_en;
      end
    end

    // Serial out forced high and receive data masked to idle while held.
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        serial_out_reg[ch] <= 1'b1;
        serial_in_reg[ch] <= 1'b1;
      end
      else
      begin
        serial_out_reg[ch] <= held ? 1'b1 : i_core_serial_out[ch];
        serial_in_reg[ch] <= held ? 1'b1
                                  : sync2_reg[uart_pin_ctrl_pkg::PIN_RX_BASE + ch];
      end
    end

    // Handshake pins are active low copies of software control bits.
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        rts_n_reg[ch] <= 1'b1;
        dtr_n_reg[ch] <= 1'b1;
      end
      else if (held)
      begin
        rts_n_reg[ch] <= 1'b1;
        dtr_n_reg[ch] <= 1'b1;
      end
      else
      begin
        rts_n_reg[ch] <= ~modem_control_reg[ch][uart_pin_ctrl_pkg::CTRL_SEND_BIT];
        dtr_n_reg[ch] <= ~modem_control_reg[ch][uart_pin_ctrl_pkg::CTRL_READY_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Modem status sensing
  // ---------------------------------------------------------------
  uart_pin_ctrl_pkg::modem_in_type stat_a_reg;
  uart_pin_ctrl_pkg::modem_in_type stat_b_reg;
  logic in_reset_reg;

  // Status is only reported; nothing in the serial path reads it.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stat_a_reg <= '1;
      stat_b_reg <= '1;
      in_reset_reg <= 1'b1;
    end
    else
    begin
      stat_a_reg <= held ? uart_pin_ctrl_pkg::STATUS_IDLE
                         : sync2_reg[uart_pin_ctrl_pkg::PIN_STAT_A_LSB +: 4];
      stat_b_reg <= held ? uart_pin_ctrl_pkg::STATUS_IDLE
                         : sync2_reg[uart_pin_ctrl_pkg::PIN_STAT_B_LSB +: 4];
      in_reset_reg <= held;
    end
  end

  assign o_serial_out_a = serial_out_reg[0];
  assign o_serial_out_b = serial_out_reg[1];
  assign o_serial_in = serial_in_reg;
  assign o_irq_out_a = pins_reg[0].irq_value;
  assign o_irq_out_a_oe = pins_reg[0].irq_enable;
  assign o_irq_out_b = pins_reg[1].irq_value;
  assign o_irq_out_b_oe = pins_reg[1].irq_enable;
  assign o_aux_out_two_n_a = pins_reg[0].aux_out_two_n;
  assign o_aux_out_two_n_b = pins_reg[1].aux_out_two_n;
  assign o_request_send_n_a = rts_n_reg[0];
  assign o_request_send_n_b = rts_n_reg[1];
  assign o_terminal_ready_n_a = dtr_n_reg[0];
  assign o_terminal_ready_n_b = dtr_n_reg[1];
  assign o_modem_status_a = stat_a_reg;
  assign o_modem_status_b = stat_b_reg;
  assign o_in_reset = in_reset_reg;

endmodule // dual_uart_pin_control

`default_nettype wire

// ### design/uart_pin_ctrl_pkg.sv
// Purpose: Shared constants and carrier types for the dual-channel pin control block.
// Assumes: One clock domain at 250 MHz.
// Notes: Modem control word is the per-channel software-visible control byte.
package uart_pin_ctrl_pkg;

  localparam int NUM_CH = 2;
  localparam int CTRL_WIDTH = 8;
  localparam int CTRL_IRQ_EN_BIT = 3;
  localparam int CTRL_SEND_BIT = 1;
  localparam int CTRL_READY_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Layout of the synchronised pin vector.
  localparam int PIN_RESET_IDX = 10;
  localparam int PIN_RX_BASE = 8;
  localparam int PIN_STAT_A_LSB = 4;
  localparam int PIN_STAT_B_LSB = 0;
  localparam logic [10:0] SYNC_PRESET = 11'h3ff;
  localparam logic [3:0] STATUS_IDLE = 4'hf;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_MIN_NS = 40;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RESET_CNT_MAX = 4'(RESET_MIN_CYC);
  localparam logic [3:0] RESET_CNT_ZERO = 4'h0;
  localparam logic [3:0] RESET_CNT_ONE = 4'h1;

  // Modem status inputs of one channel, all active low.
  typedef struct packed {
    logic carrier_detect_n;
    logic ring_indicator_n;
    logic clear_send_n;
    logic set_ready_n;
  } modem_in_type;

  // Per-channel pin drive for the interrupt pin and its companion output.
  typedef struct packed {
    logic irq_value;
    logic irq_enable;
    logic aux_out_two_n;
  } irq_pins_type;

  typedef enum logic [1:0]
  {
    ST_HELD = 2'b00,
    ST_RUN = 2'b01
  } reset_state_type;

endpackage

// ### dv/pin_ctrl_checker.sv
// Purpose: Concurrent checks on the pin control outputs.
// Assumes: One clock; the bench keeps control writes clear of device reset pulses.
// Notes: Bound to the top module after the module.
`timescale 1ns/1ns
`default_nettype none
module pin_ctrl_checker
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_reset_pin,
  input wire logic [1:0] i_ctrl_we,
  input wire logic [7:0] i_ctrl_wdata,
  input wire logic [1:0] i_irq_req,
  input wire logic [1:0] i_core_serial_out,
  input wire logic o_serial_out_a,
  input wire logic o_serial_out_b,
  input wire logic o_irq_out_a,
  input wire logic o_irq_out_a_oe,
  input wire logic o_irq_out_b_oe,
  input wire logic o_aux_out_two_n_a,
  input wire logic o_aux_out_two_n_b,
  input wire logic o_request_send_n_a,
  input wire logic o_in_reset
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  property p_aux_a; o_aux_out_two_n_a == !o_irq_out_a_oe; endproperty
  a_aux_a: assert property (p_aux_a) else $error("aux a wrong");
  property p_aux_b; o_aux_out_two_n_b == !o_irq_out_b_oe; endproperty
  a_aux_b: assert property (p_aux_b) else $error("aux b wrong");
  property p_wr_a;
    i_ctrl_we[0] && !o_in_reset |-> ##2 o_irq_out_a_oe == $past(i_ctrl_wdata[3], 2)
      && o_request_send_n_a == !$past(i_ctrl_wdata[1], 2);
  endproperty
  a_wr_a: assert property (p_wr_a) else $error("write a wrong");
  property p_wr_b;
    i_ctrl_we == 2'h2 && !o_in_reset |-> ##2 o_irq_out_b_oe == $past(i_ctrl_wdata[3], 2)
      && $stable(o_irq_out_a_oe);
  endproperty
  a_wr_b: assert property (p_wr_b) else $error("write b wrong");
  property p_irq_a; !o_in_reset && !$past(o_in_reset) |-> o_irq_out_a == $past(i_irq_req[0]);
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq a wrong");
  sequence s_run; !o_in_reset && !$past(o_in_reset); endsequence
  property p_tx_a; s_run |-> o_serial_out_a == $past(i_core_serial_out[0]); endproperty
  a_tx_a: assert property (p_tx_a) else $error("tx a wrong");
  property p_hold;
    o_in_reset |-> o_serial_out_a && o_serial_out_b && !o_irq_out_a_oe && !o_irq_out_b_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("reset outputs wrong");
  property p_qual; $rose(o_in_reset) |-> $past(i_reset_pin, 4) && $past(i_reset_pin, 14);
  endproperty
  a_qual: assert property (p_qual) else $error("short reset taken");
  c_oe_a: cover property (o_irq_out_a_oe);
  c_oe_b: cover property (o_irq_out_b_oe && !o_irq_out_a_oe);
  c_rst: cover property ($rose(o_in_reset));
endmodule // pin_ctrl_checker
bind dual_uart_pin_control pin_ctrl_checker u_pin_ctrl_checker (.i_mclk, .i_arst_n,
  .i_reset_pin, .i_ctrl_we, .i_ctrl_wdata, .i_irq_req, .i_core_serial_out, .o_serial_out_a,
  .o_serial_out_b, .o_irq_out_a, .o_irq_out_a_oe, .o_irq_out_b_oe, .o_aux_out_two_n_a,
  .o_aux_out_two_n_b, .o_request_send_n_a, .o_in_reset);
`default_nettype wire

// ### dv/pin_partner.sv
// Purpose: Line-side model driving receive and modem status pins.
// Assumes: Driven from the bench clock edges.
// Notes: Lines rest high whenever no traffic is commanded.
`timescale 1ns/1ns
`default_nettype none
module pin_partner
(
  input wire logic i_active,
  input wire logic [1:0] i_rx,
  input wire logic [3:0] i_md_a,
  input wire logic [3:0] i_md_b,
  output logic [1:0] o_rx,
  output uart_pin_ctrl_pkg::modem_in_type o_md_a,
  output uart_pin_ctrl_pkg::modem_in_type o_md_b
);
  // Output-port-2 pins are never reused here as general outputs.
  assign o_rx = i_active ? i_rx : 2'h3;
  assign o_md_a = i_active ? i_md_a : 4'hf;
  assign o_md_b = i_active ? i_md_b : 4'hf;
endmodule // pin_partner
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: Self-checking bench for the dual channel pin control block.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes: Outputs are sampled at falling edges.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_mclk = 1'b0, i_arst_n = 1'b0, i_reset_pin = 1'b0, act = 1'b0;
  logic [1:0] i_ctrl_we = 2'h0, i_irq_req = 2'h0, i_core_serial_out = 2'h3, rxv = 2'h3, rx;
  logic [7:0] i_ctrl_wdata = 8'h00;
  logic [3:0] mva = 4'hf, mvb = 4'hf;
  uart_pin_ctrl_pkg::modem_in_type md_a, md_b, o_modem_status_a, o_modem_status_b;
  logic o_serial_out_a, o_serial_out_b, o_irq_out_a, o_irq_out_a_oe, o_irq_out_b, o_irq_out_b_oe;
  logic o_aux_out_two_n_a, o_aux_out_two_n_b, o_request_send_n_a, o_request_send_n_b, o_in_reset;
  logic o_terminal_ready_n_a, o_terminal_ready_n_b;
  logic [1:0] o_serial_in;
  int n_mismatch = 0;
  int n_tests = 0;
  always #2 i_mclk = ~i_mclk;
  pin_partner u_pin_partner (.i_active(act), .i_rx(rxv), .i_md_a(mva), .i_md_b(mvb),
    .o_rx(rx), .o_md_a(md_a), .o_md_b(md_b));
  dual_uart_pin_control u_dual_uart_pin_control (.i_mclk, .i_arst_n, .i_reset_pin, .i_ctrl_we,
    .i_ctrl_wdata, .i_irq_req, .i_core_serial_out, .i_serial_in_a(rx[0]), .i_serial_in_b(rx[1]),
    .i_carrier_detect_n_a(md_a.carrier_detect_n), .i_carrier_detect_n_b(md_b.carrier_detect_n),
    .i_ring_indicator_n_a(md_a.ring_indicator_n), .i_ring_indicator_n_b(md_b.ring_indicator_n),
    .i_clear_send_n_a(md_a.clear_send_n), .i_clear_send_n_b(md_b.clear_send_n),
    .i_set_ready_n_a(md_a.set_ready_n), .i_set_ready_n_b(md_b.set_ready_n), .o_serial_out_a,
    .o_serial_out_b, .o_serial_in, .o_irq_out_a, .o_irq_out_a_oe, .o_irq_out_b, .o_irq_out_b_oe,
    .o_aux_out_two_n_a, .o_aux_out_two_n_b, .o_request_send_n_a, .o_request_send_n_b,
    .o_terminal_ready_n_a, .o_terminal_ready_n_b, .o_modem_status_a, .o_modem_status_b,
    .o_in_reset);
  wire logic [3:0] pa = {o_irq_out_a_oe, o_aux_out_two_n_a, o_request_send_n_a, o_terminal_ready_n_a};
  wire logic [3:0] pb = {o_irq_out_b_oe, o_aux_out_two_n_b, o_request_send_n_b, o_terminal_ready_n_b};
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [1:0] ch, input logic [7:0] d);
    @(posedge i_mclk);
    i_ctrl_we <= ch;
    i_ctrl_wdata <= d;
    @(posedge i_mclk);
    i_ctrl_we <= 2'h0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic t_chan();
    chk("pins_a", 4'h7, pa);
    wr(2'h1, 8'h0b);
    chk("pins_a", 4'h8, pa);
    chk("pins_b", 4'h7, pb);
    wr(2'h2, 8'h08);
    chk("pins_b", 4'hb, pb);
    @(posedge i_mclk);
    i_irq_req <= 2'h2;
    @(posedge i_mclk);
    @(negedge i_mclk);
    chk("irq", 4'h2, {o_irq_out_b, o_irq_out_a});
    wr(2'h1, 8'h00);
    chk("pins_a", 4'h7, pa);
    chk("pins_b", 4'hb, pb);
  endtask
  task automatic t_modem();
    @(posedge i_mclk);
    {act, rxv, mva, mvb, i_core_serial_out} <= {1'b1, 2'h2, 4'h5, 4'ha, 2'h2};
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("stat_a", 4'h5, o_modem_status_a);
    chk("stat_b", 4'ha, o_modem_status_b);
    chk("rx", 4'h2, o_serial_in);
    chk("tx", 4'h2, {o_serial_out_b, o_serial_out_a});
  endtask
  task automatic t_reset();
    @(posedge i_mclk);
    i_reset_pin <= 1'b1;
    i_core_serial_out <= 2'h0;
    rxv <= 2'h0;
    repeat (10) @(posedge i_mclk);
    i_reset_pin <= 1'b0;
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("short", 4'h0, o_in_reset);
    @(posedge i_mclk);
    i_reset_pin <= 1'b1;
    repeat (16) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("held", 4'h1, o_in_reset);
    chk("tx_hold", 4'h3, {o_serial_out_b, o_serial_out_a});
    chk("rx_ign", 4'h3, o_serial_in);
    chk("pins_b", 4'h7, pb);
    @(posedge i_mclk);
    {i_reset_pin, act, i_core_serial_out} <= {1'b0, 1'b0, 2'h3};
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("run", 4'h0, o_in_reset);
    chk("pins_b", 4'h7, pb);
  endtask
  initial
  begin
    repeat (8) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    t_chan();
    t_modem();
    t_reset();
    final_report();
  end
  initial
  begin
    #4000;
    n_mismatch++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
